// >>> design/qpi_ctl_pkg.sv
// shared constants, types and decode functions for the qpi mode control
package qpi_ctl_pkg;

	// clock rate and software reset recovery time
	localparam int CLK_MHZ     = 40;
	localparam int RST_TIME_US = 30;
	localparam int RST_CYC     = RST_TIME_US * CLK_MHZ;
	localparam int RST_CNT_W   = $clog2(RST_CYC + 1);

	// opcodes handled here
	localparam logic [7:0] OP_WRAP_RD   = 8'h0C;
	localparam logic [7:0] OP_SET_PARAM = 8'hC0;
	localparam logic [7:0] OP_ENTER_QPI = 8'h38;
	localparam logic [7:0] OP_EXIT_QPI  = 8'hFF;
	localparam logic [7:0] OP_EN_RST    = 8'h66;
	localparam logic [7:0] OP_RST       = 8'h99;

	// clock edges of a frame at which each field is complete
	localparam logic [4:0] SPI_OP_EDGES    = 5'h08;
	localparam logic [4:0] QPI_OP_EDGES    = 5'h02;
	localparam logic [4:0] QPI_PARAM_EDGES = 5'h04;
	localparam logic [4:0] QPI_ADDR_END    = 5'h08;
	localparam logic [4:0] ECNT_MAX        = 5'h1F;
	localparam logic [4:0] ONE_EDGE        = 5'h01;

	// read parameter layout and defaults (8 dummy clocks, 8-byte wrap)
	localparam int         PRM_DUMMY_LSB  = 4;
	localparam int         PRM_WRAP_LSB   = 0;
	localparam logic [7:0] READ_PARAM_RST = 8'h30;
	localparam logic [7:0] ERASED_BYTE    = 8'hFF;
	localparam logic [4:0] DUMMY_SHORT    = 5'h04;
	localparam logic [4:0] DUMMY_MID      = 5'h06;
	localparam logic [4:0] DUMMY_LONG     = 5'h08;
	localparam logic [6:0] WRAP_BASE      = 7'h08;

	// raw frame as left behind by the link shifters
	typedef struct packed {
		logic [4:0] edges;
		logic [7:0] spi_op;
		logic [7:0] qpi_op;
		logic [7:0] qpi_prm;
	} frame_t;

	// quasi-static settings handed to the link side
	typedef struct packed {
		logic       qpi;
		logic       busy;
		logic [4:0] dummy;
		logic [5:0] wrap_mask;
	} link_cfg_t;

	// requests from the rest of the device, same clock
	typedef struct packed {
		logic       wel_set;
		logic       wel_clr;
		logic       sus_set;
		logic       sus_clr;
		logic       cont_wr;
		logic [7:0] cont_val;
		logic       wrap_wr;
		logic [2:0] wrap_val;
	} dev_ctl_t;

	// state shown to the rest of the device
	typedef struct packed {
		logic       qpi;
		logic       write_enable_latch;
		logic       suspend_flag;
		logic       rst_busy;
		logic [7:0] read_parameter_bits;
		logic [7:0] continuous_read_bits;
		logic [2:0] wrap_setting_bits;
	} dev_stat_t;

	// array byte load port
	typedef struct packed {
		logic        en;
		logic [23:0] addr;
		logic [7:0]  data;
	} array_wr_t;

	// dummy clocks selected by the read parameters
	function automatic logic [4:0] dummy_of(input logic [7:0] p);
		case (p[PRM_DUMMY_LSB +: 2])
			2'h2:    dummy_of = DUMMY_MID;
			2'h3:    dummy_of = DUMMY_LONG;
			default: dummy_of = DUMMY_SHORT;
		endcase
	endfunction

	// wrap window mask, window is 8, 16, 32 or 64 bytes
	function automatic logic [5:0] wrap_mask_of(input logic [7:0] p);
		logic [6:0] len;
		len = WRAP_BASE << p[PRM_WRAP_LSB +: 2];
		wrap_mask_of = 6'(len - 7'h01);
	endfunction

endpackage

// >>> design/flash_array_mem.sv
// dual clock byte array, erased at start, registered read data
`timescale 1ns/10ps
module flash_array_mem
	import qpi_ctl_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          clock,   // write clock
	input  wire array_wr_t     wr,      // byte load
	input  wire logic          rclk,    // read clock
	input  wire logic          rd_en,   // read strobe
	input  wire logic [AW-1:0] rd_addr, // read address
	output logic      [7:0]    rd_data  // read byte, registered
);
	logic [7:0] mem [2**AW];

	// array leaves delivery erased to all ones
	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = ERASED_BYTE;
		end
	end

	// load port
	always_ff @(posedge clock) begin
		if (wr.en) begin
			mem[wr.addr[AW-1:0]] <= wr.data;
		end
	end

	// read port on the link clock
	always_ff @(posedge rclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// >>> design/qpi_mode_ctl.sv
// spi/qpi mode switch, wrapped burst read and software reset control
`timescale 1ns/10ps
module qpi_mode_ctl
	import qpi_ctl_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic       clock,              // system clock, 40 MHz
	input  wire logic       rst_b,              // sync reset, low
	input  wire logic       sclk,               // link serial clock
	input  wire logic       cs_b,               // chip select, low
	input  wire logic [3:0] io_i,               // io pins in
	output logic      [3:0] io_o,               // io pins out
	output logic      [3:0] io_oe,              // io drive enable
	input  wire logic       quad_io_enable_bit, // quad enable level
	input  wire dev_ctl_t   ctl,                // flag requests
	input  wire array_wr_t  array_wr,           // array byte load
	output dev_stat_t       status,             // device state
	output logic            cmd_valid,          // accepted opcode pulse
	output logic      [7:0] cmd_code,           // accepted opcode
	output logic            cmd_reject,         // rejected, reset busy
	output logic            abort               // abort internal op
);
	// elaboration check: window of 64 bytes must fit the array
	if (ADDR_W < 6 || ADDR_W > 24) begin : g_bad_aw
		$error("ADDR_W must be 6 to 24");
	end

	// system side state
	logic                 cs_s1_q, cs_s2_q, cs_s3_q;
	logic                 qpi_q, wel_q, sus_q, armed_q, rst_busy_q;
	logic [RST_CNT_W-1:0] rst_cnt_q;
	logic [7:0]           read_param_q, cont_q;
	logic [2:0]           wrap_bits_q;
	logic                 cmd_valid_q, cmd_reject_q, abort_q;
	logic [7:0]           cmd_code_q;
	// link side state
	logic                 fresh_q, wrap_rd_q, dphase_q, nib_sel_q;
	logic [4:0]           ecnt_q;
	logic [7:0]           spi_op_q, qpi_op_q, qpi_prm_q, rd_data;
	logic [ADDR_W-1:0]    addr_sh_q, rd_addr_q;
	link_cfg_t            cfg_q;
	logic [3:0]           io_o_q, io_oe_q;
	// combinational
	logic [4:0]           e;
	logic                 launch;
	frame_t               frm;
	logic                 frame_done, complete, accept, do_reset;
	logic [7:0]           op;
	link_cfg_t            cfg_sys;

	// hardware set wins over a same-cycle clear
	function automatic logic flag_next(input logic q, input logic set,
		input logic clr);
		flag_next = set | (q & ~clr);
	endfunction

	// next address inside the aligned wrap window
	function automatic logic [ADDR_W-1:0] wrap_next(
		input logic [ADDR_W-1:0] a, input logic [5:0] m);
		logic [ADDR_W-1:0] mk;
		mk = ADDR_W'(m);
		wrap_next = (a & ~mk) | ((a + 1'b1) & mk);
	endfunction

	// ---- link clock domain ----

	// set while chip select is high, so the first edge restarts the frame
	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	assign e = fresh_q ? 5'h00 : ecnt_q;

	// edge counter saturates so long reads do not alias short frames
	always_ff @(posedge sclk) begin
		ecnt_q <= (e == ECNT_MAX) ? ECNT_MAX : 5'(e + ONE_EDGE);
	end

	// both framings are shifted, the system side picks one by mode
	always_ff @(posedge sclk) begin
		if (e < SPI_OP_EDGES) begin
			spi_op_q <= {spi_op_q[6:0], io_i[0]};
		end
		if (e < QPI_OP_EDGES) begin
			qpi_op_q <= {qpi_op_q[3:0], io_i};
		end else if (e < QPI_PARAM_EDGES) begin
			qpi_prm_q <= {qpi_prm_q[3:0], io_i};
		end
	end

	// settings change only while chip select is high, except busy clearing when recovery ends; take them at start
	always_ff @(posedge sclk) begin
		if (fresh_q) begin
			cfg_q <= cfg_sys;
		end
	end

	// wrapped read is recognised in qpi framing only
	always_ff @(posedge sclk) begin
		if (fresh_q) begin
			wrap_rd_q <= 1'b0;
		end else if (e == QPI_OP_EDGES - ONE_EDGE) begin
			wrap_rd_q <= cfg_q.qpi && !cfg_q.busy &&
				({qpi_op_q[3:0], io_i} == OP_WRAP_RD);
		end
	end

	// address nibbles follow the opcode; low bits kept
	always_ff @(posedge sclk) begin
		if (e >= QPI_OP_EDGES && e < QPI_ADDR_END) begin
			addr_sh_q <= {addr_sh_q[ADDR_W-5:0], io_i};
		end
	end

	// read launched on the last dummy edge, then every second edge;
	// blocked on a frame's first edge, where the phase flags are stale
	assign launch = wrap_rd_q && !fresh_q &&
		((e == 5'(QPI_ADDR_END + cfg_q.dummy - ONE_EDGE)) ||
		 (dphase_q && nib_sel_q));

	// address steps and wraps at the window end
	always_ff @(posedge sclk) begin
		if (e == QPI_ADDR_END) begin
			rd_addr_q <= addr_sh_q;
		end else if (launch) begin
			rd_addr_q <= wrap_next(rd_addr_q, cfg_q.wrap_mask);
		end
	end

	// data phase tracking and nibble order, high nibble first
	always_ff @(posedge sclk) begin
		if (fresh_q) begin
			dphase_q <= 1'b0;
		end else if (launch) begin
			dphase_q <= 1'b1;
		end
		nib_sel_q <= !launch;
	end

	flash_array_mem #(
		.AW(ADDR_W)
	) u_array (
		.clock   (clock),
		.wr      (array_wr),
		.rclk    (sclk),
		.rd_en   (launch),
		.rd_addr (rd_addr_q),
		.rd_data (rd_data)
	);

	// drive on the falling edge; chip select high releases the pins
	always_ff @(negedge sclk or posedge cs_b) begin
		if (cs_b) begin
			io_o_q  <= 4'h0;
			io_oe_q <= 4'h0;
		end else begin
			io_o_q  <= nib_sel_q ? rd_data[3:0] : rd_data[7:4];
			io_oe_q <= {4{dphase_q}};
		end
	end

	// ---- system clock domain ----

	// chip select level crossing; link registers are idle once it is high
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_b;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
		end
	end

	// frame decode in the current mode only
	always_comb begin
		frm        = '{edges: ecnt_q, spi_op: spi_op_q, qpi_op: qpi_op_q,
			qpi_prm: qpi_prm_q};
		frame_done = cs_s2_q && !cs_s3_q;
		op         = qpi_q ? frm.qpi_op : frm.spi_op;
		complete   = frm.edges >= (qpi_q ? QPI_OP_EDGES : SPI_OP_EDGES);
		accept     = frame_done && complete && !rst_busy_q;
		do_reset   = accept && (op == OP_RST) && armed_q;
		cfg_sys    = '{qpi: qpi_q, busy: rst_busy_q,
			dummy: dummy_of(read_param_q),
			wrap_mask: wrap_mask_of(read_param_q)};
	end

	// reset arming: only the very next command may fire it
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			armed_q <= 1'b0;
		end else if (accept) begin
			armed_q <= (op == OP_EN_RST);
		end
	end

	// interface mode
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			qpi_q <= 1'b0;
		end else if (do_reset) begin
			qpi_q <= 1'b0;
		end else if (accept && !qpi_q && op == OP_ENTER_QPI &&
			quad_io_enable_bit && frm.edges == SPI_OP_EDGES) begin
			qpi_q <= 1'b1;
		end else if (accept && qpi_q && op == OP_EXIT_QPI &&
			frm.edges == QPI_OP_EDGES) begin
			qpi_q <= 1'b0;
		end
	end

	// read parameters, set in qpi only; mode switches leave them alone
	always_ff @(posedge clock) begin
		if (!rst_b || do_reset) begin
			read_param_q <= READ_PARAM_RST;
		end else if (accept && qpi_q && op == OP_SET_PARAM &&
			frm.edges >= QPI_PARAM_EDGES) begin
			read_param_q <= frm.qpi_prm;
		end
	end

	// volatile flags; a reset aborts, so it beats any set
	always_ff @(posedge clock) begin
		if (!rst_b || do_reset) begin
			wel_q       <= 1'b0;
			sus_q       <= 1'b0;
			cont_q      <= 8'h00;
			wrap_bits_q <= 3'h0;
		end else if (!rst_busy_q) begin
			wel_q <= flag_next(wel_q, ctl.wel_set, ctl.wel_clr);
			sus_q <= flag_next(sus_q, ctl.sus_set, ctl.sus_clr);
			if (ctl.cont_wr) begin
				cont_q <= ctl.cont_val;
			end
			if (ctl.wrap_wr) begin
				wrap_bits_q <= ctl.wrap_val;
			end
		end
	end

	// reset recovery timer
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rst_busy_q <= 1'b0;
			rst_cnt_q  <= '0;
		end else if (do_reset) begin
			rst_busy_q <= 1'b1;
			rst_cnt_q  <= RST_CNT_W'(RST_CYC - 1);
		end else if (rst_busy_q) begin
			if (rst_cnt_q == '0) begin
				rst_busy_q <= 1'b0;
			end else begin
				rst_cnt_q <= rst_cnt_q - 1'b1;
			end
		end
	end

	// command strobes to the rest of the device
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cmd_valid_q  <= 1'b0;
			cmd_code_q   <= 8'h00;
			cmd_reject_q <= 1'b0;
			abort_q      <= 1'b0;
		end else begin
			cmd_valid_q  <= accept;
			cmd_code_q   <= accept ? op : cmd_code_q;
			cmd_reject_q <= frame_done && complete && rst_busy_q;
			abort_q      <= do_reset;
		end
	end

	assign io_o       = io_o_q;
	assign io_oe      = io_oe_q;
	assign cmd_valid  = cmd_valid_q;
	assign cmd_code   = cmd_code_q;
	assign cmd_reject = cmd_reject_q;
	assign abort      = abort_q;
	assign status     = '{qpi: qpi_q, write_enable_latch: wel_q,
		suspend_flag: sus_q, rst_busy: rst_busy_q,
		read_parameter_bits: read_param_q, continuous_read_bits: cont_q,
		wrap_setting_bits: wrap_bits_q};

	// ---- checks ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_enter_only;
		$rose(qpi_q) |-> $past(accept && op == OP_ENTER_QPI &&
			quad_io_enable_bit);
	endproperty
	a_enter_only: assert property (p_enter_only)
		else $error("qpi entered without enter opcode");

	property p_exit;
		accept && qpi_q && op == OP_EXIT_QPI && frm.edges == QPI_OP_EDGES
			|=> !qpi_q;
	endproperty
	a_exit: assert property (p_exit)
		else $error("exit opcode did not leave qpi");

	property p_keep;
		$changed(qpi_q) && !$past(do_reset) |->
			$stable(read_param_q) && $stable(wrap_bits_q);
	endproperty
	a_keep: assert property (p_keep)
		else $error("mode switch disturbed settings");

	property p_reset_clear;
		do_reset |=> !qpi_q && !wel_q && !sus_q && cont_q == 8'h00 &&
			wrap_bits_q == 3'h0 && read_param_q == READ_PARAM_RST;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("reset left volatile state");

	property p_arm;
		$rose(rst_busy_q) |-> $past(armed_q && op == OP_RST && accept);
	endproperty
	a_arm: assert property (p_arm)
		else $error("reset fired without enable");

	property p_disarm;
		accept && op != OP_EN_RST |=> !armed_q;
	endproperty
	a_disarm: assert property (p_disarm)
		else $error("reset stayed armed");

	property p_busy;
		$fell(rst_busy_q) |-> $past(rst_cnt_q == '0);
	endproperty
	a_busy: assert property (p_busy)
		else $error("reset recovery ended early");

	property p_reject;
		frame_done && complete && rst_busy_q |=>
			cmd_reject_q && !cmd_valid_q && $stable(qpi_q);
	endproperty
	a_reject: assert property (p_reject)
		else $error("command taken during reset");

	property p_param;
		accept && qpi_q && op == OP_SET_PARAM &&
			frm.edges >= QPI_PARAM_EDGES |=>
			read_param_q == $past(frm.qpi_prm);
	endproperty
	a_param: assert property (p_param)
		else $error("read parameters not loaded");

	property p_wrap;
		@(posedge sclk) disable iff (cs_b)
		launch && !(e == QPI_ADDR_END) |=>
			((rd_addr_q ^ $past(rd_addr_q)) &
			~ADDR_W'($past(cfg_q.wrap_mask))) == '0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("wrapped read left its window");
endmodule

// >>> sim/host_link_model.sv
// host side spi/qpi controller model driving the link pins
`timescale 1ns/10ps
module host_link_model (
	output logic            sclk,  // serial clock, still outside frames
	output logic            cs_b,  // chip select, low
	output wire logic [3:0] io_i,  // resolved io level seen by the device
	input  wire logic [3:0] io_o,  // device io out
	input  wire logic [3:0] io_oe  // device io drive enable
);
	logic [3:0] drv;     // host drive value
	logic [3:0] rx_q[$]; // nibbles sampled in the read phase

	// a wire carries the device value only where the device drives it
	assign io_i = (io_oe & io_o) | (~io_oe & drv);

	initial begin
		sclk = 1'b0;
		// late in the step, so the pin release logic sees the rise
		cs_b <= 1'b1;
		drv  = 4'h5;
	end

	// one frame, one unit per edge (nibble or bit0), idle lines toggle
	// so a stale value can never pass for a driven one
	task automatic frame(input logic qm, input logic [3:0] tx[$],
		input int n, input int rd_at);
		rx_q.delete();
		#3.7 cs_b <= 1'b0;
		for (int e = 0; e < n; e++) begin
			if (e < tx.size()) begin
				drv <= qm ? tx[e] : {~drv[3:1], tx[e][0]};
			end else begin
				drv <= ~drv;
			end
			#32;
			if (e >= rd_at) begin
				rx_q.push_back(io_i);
			end
			sclk <= 1'b1;
			#32 sclk <= 1'b0;
		end
		#20 cs_b <= 1'b1;
		drv <= ~drv;
	endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the qpi mode and software reset control
`timescale 1ns/10ps
module testbench;
	import qpi_ctl_pkg::*;
	localparam int AW = 8;
	logic        clock, rst_b, quad_io_enable_bit;
	dev_ctl_t    ctl;
	array_wr_t   array_wr;
	wire  logic  sclk, cs_b;
	wire  logic [3:0] io_i;
	logic [3:0]  io_o, io_oe;
	dev_stat_t   status;
	logic        cmd_valid, cmd_reject, abort;
	logic [7:0]  cmd_code, p, b;
	logic [23:0] a;
	logic [5:0]  m;
	logic [4:0]  kv;
	logic [10:0] note_q[$]; // {reject, abort, qpi, code}
	logic [3:0]  tail[$];
	logic [7:0]  mem[2**AW];
	int          err_count, n_compared, n, d, busy_n, seed;

	qpi_mode_ctl #(.ADDR_W(AW)) dut_u (.clock(clock), .rst_b(rst_b),
		.sclk(sclk), .cs_b(cs_b), .io_i(io_i), .io_o(io_o), .io_oe(io_oe),
		.quad_io_enable_bit(quad_io_enable_bit), .ctl(ctl),
		.array_wr(array_wr), .status(status), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_reject(cmd_reject), .abort(abort));
	host_link_model host_u (.sclk(sclk), .cs_b(cs_b), .io_i(io_i),
		.io_o(io_o), .io_oe(io_oe));

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	task automatic check(input logic [31:0] got, exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg,
				got, exp);
		end
	endtask

	task automatic finish_test();
		if (err_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// opcode frame plus queued tail units; note the event it should give
	task automatic send(input logic qm, input logic [7:0] c,
		input logic [10:0] nt, input bit noted, input int extra,
		input int rd);
		logic [3:0] u[$];
		if (qm) u = {c[7:4], c[3:0]};
		else for (int i = 7; i >= 0; i--) u.push_back({3'h0, c[i]});
		u = {u, tail};
		tail.delete();
		if (noted) note_q.push_back(nt);
		host_u.frame(qm, u, u.size() + extra, rd);
		repeat (10) @(posedge clock); // gap well above six clocks
	endtask

	task automatic pulse(input dev_ctl_t v);
		ctl <= v;
		@(posedge clock);
		ctl <= '0;
		@(posedge clock);
	endtask

	function automatic logic [4:0] kept(input dev_stat_t s);
		kept = {s.write_enable_latch, s.suspend_flag, s.wrap_setting_bits};
	endfunction

	// each decoded event is compared with the oldest note
	always @(negedge clock) begin
		if (rst_b === 1'b1 && (cmd_valid !== 1'b0 || cmd_reject !== 1'b0)) begin
			if (note_q.size() == 0) check(1, 0, "unexpected event");
			else check({cmd_reject, abort, status.qpi, cmd_valid === 1'b1 ?
				cmd_code : 8'h00}, note_q.pop_front(), "event");
		end
	end

	// recovery length in clocks, sampled before each edge's update
	always @(posedge clock) if (status.rst_busy === 1'b1) busy_n++;

	initial begin
		#1000000;
		err_count++;
		finish_test();
	end

	initial begin
		seed = $urandom(32'h8dd11b40);
		{rst_b, quad_io_enable_bit, err_count, n_compared, busy_n} = '0;
		ctl = '0;
		array_wr = '0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		repeat (8000) @(posedge clock);
		check(status, {4'h0, READ_PARAM_RST, 11'h000}, "reset");
		// fill the low part, top bytes stay erased
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = ERASED_BYTE;
			if (i < 2**AW - 16) begin
				mem[i] = 8'($urandom);
				array_wr <= '{en: 1'b1, addr: 24'(i), data: mem[i]};
				@(posedge clock);
			end
		end
		array_wr <= '0;
		send(0, OP_ENTER_QPI, {3'h0, OP_ENTER_QPI}, 1, 0, 999);
		check(status.qpi, 1'b0, "qe clear");
		b = 8'($urandom);
		pulse('{wel_set: 1'b1, sus_set: 1'b1, cont_wr: 1'b1, cont_val: b,
			wrap_wr: 1'b1, wrap_val: b[2:0], default: '0});
		kv = {2'h3, b[2:0]};
		quad_io_enable_bit <= 1'b1;
		send(0, OP_ENTER_QPI, {3'h1, OP_ENTER_QPI}, 1, 0, 999);
		check(kept(status), kv, "kept on entry");
		send(1, OP_ENTER_QPI, {3'h1, OP_ENTER_QPI}, 1, 0, 999);
		check(status.qpi, 1'b1, "enter in qpi");
		// every wrap length and dummy code, read past the window end
		for (int w = 0; w < 4; w++) begin
			p = {2'h0, 2'(w), 2'h0, 2'(w)};
			tail = {p[7:4], p[3:0]};
			send(1, OP_SET_PARAM, {3'h1, OP_SET_PARAM}, 1, 0, 999);
			check(status.read_parameter_bits, p, "params");
			d = (w == 3) ? 8 : (w == 2) ? 6 : 4;
			m = 6'((8 << w) - 1);
			n = (8 << w) + 2;
			a = 24'($urandom);
			for (int i = 5; i >= 0; i--) tail.push_back(a[i*4 +: 4]);
			send(1, OP_WRAP_RD, {3'h1, OP_WRAP_RD}, 1, d + 2 * n, 8 + d);
			for (int i = 0; i < n; i++) begin
				b = mem[AW'((a & ~24'(m)) | ((a + 24'(i)) & 24'(m)))];
				check({host_u.rx_q[2*i], host_u.rx_q[2*i+1]}, b, "wrap");
			end
		end
		send(1, OP_EXIT_QPI, {3'h0, OP_EXIT_QPI}, 1, 0, 999);
		check(kept(status), kv, "kept on exit");
		send(0, OP_EXIT_QPI, {3'h0, OP_EXIT_QPI}, 1, 0, 999);
		send(0, OP_EN_RST, {3'h0, OP_EN_RST}, 1, 0, 999);
		send(0, OP_EXIT_QPI, {3'h0, OP_EXIT_QPI}, 1, 0, 999);
		send(0, OP_RST, {3'h0, OP_RST}, 1, 0, 999);
		send(0, OP_ENTER_QPI, {3'h1, OP_ENTER_QPI}, 1, 0, 999);
		check(status.rst_busy, 1'b0, "idle before reset");
		send(1, OP_EN_RST, {3'h1, OP_EN_RST}, 1, 0, 999);
		host_u.frame(1, {4'h3}, 1, 999); // short frame must not disarm
		repeat (10) @(posedge clock);
		busy_n = 0;
		send(1, OP_RST, {3'h2, OP_RST}, 1, 0, 999);
		check(status, {4'h1, READ_PARAM_RST, 11'h000}, "sw reset");
		send(0, OP_EN_RST, {3'h4, 8'h00}, 1, 0, 999);
		for (int i = 0; i < 2000 && status.rst_busy !== 1'b0; i++) begin
			@(posedge clock);
		end
		repeat (2) @(posedge clock);
		check(busy_n, RST_CYC, "recovery");
		send(0, OP_EN_RST, {3'h0, OP_EN_RST}, 1, 0, 999);
		check(note_q.size(), 0, "events left");
		finish_test();
	end
endmodule
